// ---- common/sync_pulse_pkg.sv ----
// Purpose: shared constants for the output sync pulse control block
// Assumes: pclk at 100 MHz, APB slave with 32-bit data
// Notes: register offsets are byte addresses
package sync_pulse_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_COMMAND = 8'h08;
  localparam logic [7:0] ADDR_PWM_PERIOD = 8'h0C;
  localparam logic [7:0] ADDR_PWM_DUTY = 8'h10;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_ON_INV = 0;
  localparam int CTRL_OFF_INV = 1;
  localparam int CTRL_ON_FUNC_LO = 2;
  localparam int CTRL_OFF_FUNC_LO = 4;
  localparam int CTRL_ON_VAL_LO = 6;
  localparam int CTRL_OFF_VAL_LO = 8;
  localparam int CTRL_WIDTH = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // ----------------------------------------------------------------
  // status and command fields
  // ----------------------------------------------------------------
  localparam int STAT_OUTPUT_ON = 0;
  localparam int STAT_ON_LEVEL = 1;
  localparam int STAT_OFF_LEVEL = 2;
  localparam int STAT_ON_TX = 3;
  localparam int STAT_OFF_TX = 4;
  localparam int STAT_ON_SEEN = 8;
  localparam int STAT_OFF_SEEN = 9;
  localparam int CMD_SWITCH_ON = 0;
  localparam int CMD_SWITCH_OFF = 1;

  // ----------------------------------------------------------------
  // pwm defaults
  // ----------------------------------------------------------------
  localparam int PWM_WIDTH = 16;
  localparam logic [15:0] PWM_PERIOD_RESET = 16'h03E8;
  localparam logic [15:0] PWM_DUTY_RESET = 16'h01F4;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PULSE_MIN_NS = 30000;
  localparam int PULSE_CYCLES = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CNT_W = 12;

  // ----------------------------------------------------------------
  // line modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    func_sync = 2'b00,
    func_input = 2'b01,
    func_output = 2'b10,
    func_idle = 2'b11
  } line_func_t;

  typedef enum logic [1:0] {
    val_true = 2'b00,
    val_false = 2'b01,
    val_pwm = 2'b10,
    val_none = 2'b11
  } line_val_t;

  typedef enum logic {
    tx_idle = 1'b0,
    tx_pulse = 1'b1
  } tx_state_t;

endpackage

// ---- sim/output_sync_pulse_control_bench.sv ----
// Purpose: self-checking bench for the output sync pulse control block
// Assumes: short pulse length parameter for simulation
// Notes: exp_on models the output switch state
`timescale 1ns/100ps
module output_sync_pulse_control_bench;
  localparam int PL = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic panel_toggle = 1'b0;
  logic inv_on = 1'b0;
  logic inv_off = 1'b0;
  logic send_on = 1'b0;
  logic send_off = 1'b0;
  logic [7:0] len_on = 8'h08;
  logic [7:0] len_off = 8'h08;
  logic [31:0] prdata, rd;
  logic pready, pslverr, output_on, err, on_line, off_line;
  logic sync_on_out, sync_on_oe, sync_off_out, sync_off_oe;
  logic [15:0] on_width, off_width;
  int error_cnt = 0;
  int checks_done = 0;
  int exp_on = 0;
  int len, hits;
  integer seed = 32'h996d_f737;

  initial forever #5 pclk = ~pclk;

  output_sync_pulse_control #(.PULSE_LEN(PL)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .panel_toggle(panel_toggle), .output_on(output_on), .sync_on_in(on_line),
    .sync_on_out(sync_on_out), .sync_on_oe(sync_on_oe), .sync_off_in(off_line),
    .sync_off_out(sync_off_out), .sync_off_oe(sync_off_oe));
  peer_sync_line i_peer_on (.pclk(pclk), .dut_out(sync_on_out), .dut_oe(sync_on_oe),
    .act_high(inv_on), .send(send_on), .send_len(len_on), .line(on_line),
    .last_width(on_width));
  peer_sync_line i_peer_off (.pclk(pclk), .dut_out(sync_off_out), .dut_oe(sync_off_oe),
    .act_high(inv_off), .send(send_off), .send_len(len_off), .line(off_line),
    .last_width(off_width));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    if (error_cnt == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      report_and_stop();
    end
  endtask

  task automatic press;
    @(posedge pclk);
    panel_toggle <= 1'b1;
    @(posedge pclk);
    panel_toggle <= 1'b0;
    exp_on = 1 - exp_on;
    repeat (PL + 8) @(posedge pclk);
    check(output_on, exp_on);
  endtask

  task automatic remote(input int is_on, input int n);
    @(posedge pclk);
    if (is_on != 0) send_on <= 1'b1;
    else send_off <= 1'b1;
    len_on <= n[7:0];
    len_off <= n[7:0];
    @(posedge pclk);
    send_on <= 1'b0;
    send_off <= 1'b0;
    repeat (n + 8) @(posedge pclk);
    if (n >= PL) exp_on = is_on;
    check(output_on, exp_on);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(output_on, 0);
    check({sync_on_oe, sync_off_oe, sync_on_out, sync_off_out}, 4'h3);
    apb(1'b0, sync_pulse_pkg::ADDR_CTRL, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    apb(1'b0, sync_pulse_pkg::ADDR_PWM_PERIOD, 32'h0000_0000);
    check(rd, 32'h0000_03e8);
    apb(1'b0, sync_pulse_pkg::ADDR_PWM_DUTY, 32'h0000_0000);
    check(rd, 32'h0000_01f4);
    remote(1, PL - 2);
    remote(0, PL);
    remote(1, PL + ($unsigned($random(seed)) % 8));
    remote(1, PL + ($unsigned($random(seed)) % 8));
    remote(0, PL + ($unsigned($random(seed)) % 8));
    press();
    check(on_width, PL);
    press();
    check(off_width, PL);
    apb(1'b1, sync_pulse_pkg::ADDR_CTRL, 32'h0000_0003);
    inv_on <= 1'b1;
    inv_off <= 1'b1;
    apb(1'b1, sync_pulse_pkg::ADDR_COMMAND, 32'h0000_0001);
    exp_on = 1;
    repeat (PL + 8) @(posedge pclk);
    check(output_on, exp_on);
    check(on_width, PL);
    remote(0, PL + 3);
    for (int v = 0; v < 4; v++) begin
      apb(1'b1, sync_pulse_pkg::ADDR_CTRL, 32'h0000_0028 | (v[0] ? 32'h0000_0140 : 0)
        | (v[1] ? 32'h0000_0003 : 0));
      repeat (3) @(posedge pclk);
      check({sync_on_oe, sync_off_oe}, 2'h3);
      check(sync_on_out, v[1] ^ v[0]);
      check(sync_off_out, v[1] ^ v[0]);
    end
    apb(1'b1, sync_pulse_pkg::ADDR_PWM_PERIOD, 32'h0000_0004);
    apb(1'b1, sync_pulse_pkg::ADDR_PWM_DUTY, 32'h0000_0002);
    apb(1'b1, sync_pulse_pkg::ADDR_CTRL, 32'h0000_0088);
    repeat (8) @(posedge pclk);
    hits = 0;
    repeat (40) begin
      @(posedge pclk);
      hits += (sync_on_out === 1'b1);
    end
    check(hits, 20);
    apb(1'b1, sync_pulse_pkg::ADDR_CTRL, 32'h0000_0004);
    inv_on <= 1'b0;
    inv_off <= 1'b0;
    repeat (PL) @(posedge pclk);
    send_on <= 1'b1;
    len_on <= 8'h28;
    @(posedge pclk);
    send_on <= 1'b0;
    // let the level pass the synchroniser and the level flop
    repeat (4) @(posedge pclk);
    apb(1'b0, sync_pulse_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd[sync_pulse_pkg::STAT_ON_LEVEL], 1);
    repeat (50) @(posedge pclk);
    apb(1'b0, sync_pulse_pkg::ADDR_STATUS, 32'h0000_0000);
    check(rd[sync_pulse_pkg::STAT_ON_LEVEL], 0);
    check(output_on, exp_on);
    apb(1'b0, 8'h14, 32'h0000_0000);
    check(err, 1);
    check(rd, 32'h0000_0000);
    report_and_stop();
  end
endmodule // output_sync_pulse_control_bench

// ---- sim/peer_sync_line.sv ----
// Purpose: peer instrument on one sync line
// Assumes: line idles at the inactive level through a pull
// Notes: measures the width of each active run the device drives
`timescale 1ns/100ps
module peer_sync_line (
  input wire logic pclk,
  input wire logic dut_out,
  input wire logic dut_oe,
  input wire logic act_high,
  input wire logic send,
  input wire logic [7:0] send_len,
  output logic line,
  output logic [15:0] last_width
);
  int left = 0;
  int run = 0;
  always @(posedge pclk) begin
    if (send) left <= send_len;
    else if (left > 0) left <= left - 1;
  end
  // released line falls back to the inactive level
  assign line = dut_oe ? dut_out : ((left > 0) ? act_high : ~act_high);
  always @(posedge pclk) begin
    if (dut_oe && dut_out == act_high) begin
      run <= run + 1;
    end else begin
      if (run > 0) last_width <= run[15:0];
      run <= 0;
    end
  end
endmodule // peer_sync_line

// ---- sim/sync_pulse_assertions.sv ----
// Purpose: concurrent checks on the sync line ports of the block
// Assumes: ctrl shadow tracks apb writes to the control register
// Notes: helper counters measure pulse widths and cause-to-effect ages
`timescale 1ns/100ps
module sync_pulse_checker #(
  parameter int PULSE_LEN = sync_pulse_pkg::PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic panel_toggle,
  input wire logic output_on,
  input wire logic sync_on_in,
  input wire logic sync_on_out,
  input wire logic sync_on_oe,
  input wire logic sync_off_in,
  input wire logic sync_off_out,
  input wire logic sync_off_oe
);
  // ----------------------------------------------------------------
  // helper state
  // ----------------------------------------------------------------
  logic [9:0] sh;
  logic [7:0] loc_age;
  logic [7:0] on_age;
  logic [7:0] off_age;
  int on_run;
  int off_run;
  int tx_cnt;
  wire wr_acc = psel && penable && pwrite && pready;
  wire on_act = ~sync_on_in ^ sh[0];
  wire off_act = ~sync_off_in ^ sh[1];
  wire local_req = panel_toggle || (wr_acc && paddr == sync_pulse_pkg::ADDR_COMMAND);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh <= 10'h000;
      loc_age <= 8'hff;
      on_age <= 8'hff;
      off_age <= 8'hff;
      on_run <= 0;
      off_run <= 0;
      tx_cnt <= 0;
    end else begin
      if (wr_acc && paddr == sync_pulse_pkg::ADDR_CTRL) sh <= pwdata[9:0];
      loc_age <= local_req ? 8'h00 : loc_age + {7'h00, loc_age != 8'hff};
      on_age <= (on_run >= PULSE_LEN) ? 8'h00 : on_age + {7'h00, on_age != 8'hff};
      off_age <= (off_run >= PULSE_LEN) ? 8'h00 : off_age + {7'h00, off_age != 8'hff};
      on_run <= on_act ? on_run + 1 : 0;
      off_run <= off_act ? off_run + 1 : 0;
      tx_cnt <= (sync_on_oe && sh[3:2] == 2'b00) ? tx_cnt + 1 : 0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  on_emit_a: assert property (
    panel_toggle && !output_on && sh[3:2] == 2'b00 && !sync_on_oe
    |=> output_on ##1 (sync_on_oe && sync_on_out == sh[0])) else $error("no turn-on pulse");
  off_emit_a: assert property (
    panel_toggle && output_on && sh[5:4] == 2'b00 && !sync_off_oe
    |=> !output_on ##1 (sync_off_oe && sync_off_out == sh[1])) else $error("no turn-off pulse");
  pulse_width_a: assert property (
    $fell(sync_on_oe) && sh[3:2] == 2'b00 |-> tx_cnt == PULSE_LEN) else $error("bad pulse width");
  rise_cause_a: assert property (
    $rose(output_on) |-> loc_age <= 8'h03 || on_age <= 8'h08) else $error("output on uncaused");
  fall_cause_a: assert property (
    $fell(output_on) |-> loc_age <= 8'h03 || off_age <= 8'h08) else $error("output off uncaused");
  on_qualify_a: assert property (
    sh[3:2] == 2'b00 && !output_on && !sync_on_oe && on_run == PULSE_LEN + 2 && loc_age > 8'h08
    |-> ##[0:6] output_on) else $error("remote turn-on missed");
  off_qualify_a: assert property (
    sh[5:4] == 2'b00 && output_on && !sync_off_oe && off_run == PULSE_LEN + 2 && loc_age > 8'h08
    |-> ##[0:6] !output_on) else $error("remote turn-off missed");
  out_value_a: assert property (
    sh[3:2] == 2'b10 && !sh[7]
    |=> sync_on_oe && sync_on_out == ($past(sh[0]) ^ $past(sh[6]))) else $error("bad driven level");
  input_release_a: assert property (
    sh[3:2] == 2'b01 |=> !sync_on_oe) else $error("input line driven");
endmodule // sync_pulse_checker

bind output_sync_pulse_control sync_pulse_checker #(.PULSE_LEN(PULSE_LEN)) u_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .panel_toggle(panel_toggle), .output_on(output_on), .sync_on_in(sync_on_in),
  .sync_on_out(sync_on_out), .sync_on_oe(sync_on_oe), .sync_off_in(sync_off_in),
  .sync_off_out(sync_off_out), .sync_off_oe(sync_off_oe));

// ---- src/output_sync_pulse_control.sv ----
// Purpose: turn-on and turn-off sync lines coupling output switch state
// Assumes: panel_toggle is a one-cycle pulse from pclk logic
// Notes: each line pin is split into input, output and output enable
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
module output_sync_pulse_control #(
  parameter int PULSE_LEN = sync_pulse_pkg::PULSE_CYCLES,
  parameter int PWM_W = sync_pulse_pkg::PWM_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic panel_toggle,
  output logic output_on,
  input wire logic sync_on_in,
  output logic sync_on_out,
  output logic sync_on_oe,
  input wire logic sync_off_in,
  output logic sync_off_out,
  output logic sync_off_oe
);

  localparam int CW = sync_pulse_pkg::PULSE_CNT_W;
  localparam logic [CW-1:0] TX_LAST = CW'(PULSE_LEN - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // digital bit to pin level
  function automatic logic pin_level(input logic bit_val, input logic inv);
    pin_level = ~bit_val ^ inv;
  endfunction

  // value selected in the output function
  function automatic logic out_value(input logic [1:0] sel, input logic pwm);
    case (sync_pulse_pkg::line_val_t'(sel))
      sync_pulse_pkg::val_true: out_value = 1'b1;
      sync_pulse_pkg::val_false: out_value = 1'b0;
      sync_pulse_pkg::val_pwm: out_value = pwm;
      default: out_value = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [sync_pulse_pkg::CTRL_WIDTH-1:0] ctrl;
  logic [PWM_W-1:0] pwm_period;
  logic [PWM_W-1:0] pwm_duty;
  logic [PWM_W-1:0] pwm_count;
  logic pwm_bit;
  logic on_seen;
  logic off_seen;
  sync_pulse_pkg::tx_state_t on_tx;
  sync_pulse_pkg::tx_state_t off_tx;
  logic [CW-1:0] on_tx_count;
  logic [CW-1:0] off_tx_count;
  logic on_level;
  logic off_level;
  logic on_rx_pulse;
  logic off_rx_pulse;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire logic setup_phase = psel && !penable;
  wire logic access_phase = psel && penable;
  wire logic hit_ctrl = (paddr == sync_pulse_pkg::ADDR_CTRL);
  wire logic hit_status = (paddr == sync_pulse_pkg::ADDR_STATUS);
  wire logic hit_command = (paddr == sync_pulse_pkg::ADDR_COMMAND);
  wire logic hit_period = (paddr == sync_pulse_pkg::ADDR_PWM_PERIOD);
  wire logic hit_duty = (paddr == sync_pulse_pkg::ADDR_PWM_DUTY);
  wire logic hit_any = hit_ctrl || hit_status || hit_command || hit_period || hit_duty;
  wire logic wr_en = access_phase && pwrite && hit_any;
  wire logic wr_ctrl = wr_en && hit_ctrl;
  wire logic wr_status = wr_en && hit_status;
  wire logic wr_command = wr_en && hit_command;
  wire logic wr_period = wr_en && hit_period;
  wire logic wr_duty = wr_en && hit_duty;

  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire logic on_inv = ctrl[sync_pulse_pkg::CTRL_ON_INV];
  wire logic off_inv = ctrl[sync_pulse_pkg::CTRL_OFF_INV];
  wire logic [1:0] on_func = ctrl[sync_pulse_pkg::CTRL_ON_FUNC_LO +: 2];
  wire logic [1:0] off_func = ctrl[sync_pulse_pkg::CTRL_OFF_FUNC_LO +: 2];
  wire logic [1:0] on_val = ctrl[sync_pulse_pkg::CTRL_ON_VAL_LO +: 2];
  wire logic [1:0] off_val = ctrl[sync_pulse_pkg::CTRL_OFF_VAL_LO +: 2];
  wire logic on_is_sync = (on_func == sync_pulse_pkg::func_sync);
  wire logic off_is_sync = (off_func == sync_pulse_pkg::func_sync);
  wire logic on_is_out = (on_func == sync_pulse_pkg::func_output);
  wire logic off_is_out = (off_func == sync_pulse_pkg::func_output);

  // ----------------------------------------------------------------
  // switch requests
  // ----------------------------------------------------------------
  wire logic cmd_on = wr_command && pwdata[sync_pulse_pkg::CMD_SWITCH_ON];
  wire logic cmd_off = wr_command && pwdata[sync_pulse_pkg::CMD_SWITCH_OFF];
  wire logic local_on = !output_on && (panel_toggle || cmd_on);
  wire logic local_off = output_on && (panel_toggle || cmd_off);
  wire logic remote_on = !output_on && on_is_sync && on_rx_pulse;
  wire logic remote_off = output_on && off_is_sync && off_rx_pulse;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_on <= 1'b0;
    end else if (local_on || remote_on) begin
      output_on <= 1'b1;
    end else if (local_off || remote_off) begin
      output_on <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // turn-on pulse sender
  // ----------------------------------------------------------------
  // pulse on turn-on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_tx <= sync_pulse_pkg::tx_idle;
      on_tx_count <= '0;
    end else begin
      case (on_tx)
        sync_pulse_pkg::tx_idle: begin
          on_tx_count <= '0;
          if (local_on && on_is_sync) begin
            on_tx <= sync_pulse_pkg::tx_pulse;
          end
        end
        sync_pulse_pkg::tx_pulse: begin
          on_tx_count <= on_tx_count + CW'(1);
          if (on_tx_count == TX_LAST) begin
            on_tx <= sync_pulse_pkg::tx_idle;
          end
        end
        default: on_tx <= sync_pulse_pkg::tx_idle;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // turn-off pulse sender
  // ----------------------------------------------------------------
  // pulse on turn-off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_tx <= sync_pulse_pkg::tx_idle;
      off_tx_count <= '0;
    end else begin
      case (off_tx)
        sync_pulse_pkg::tx_idle: begin
          off_tx_count <= '0;
          if (local_off && off_is_sync) begin
            off_tx <= sync_pulse_pkg::tx_pulse;
          end
        end
        sync_pulse_pkg::tx_pulse: begin
          off_tx_count <= off_tx_count + CW'(1);
          if (off_tx_count == TX_LAST) begin
            off_tx <= sync_pulse_pkg::tx_idle;
          end
        end
        default: off_tx <= sync_pulse_pkg::tx_idle;
      endcase
    end
  end

  wire logic on_busy = (on_tx == sync_pulse_pkg::tx_pulse);
  wire logic off_busy = (off_tx == sync_pulse_pkg::tx_pulse);

  // ----------------------------------------------------------------
  // receivers
  // ----------------------------------------------------------------
  // own pulse is blanked so a sender does not retrigger itself
  // receive turn-on pulses
  sync_line_rx #(
    .MIN_CYCLES(PULSE_LEN)
  ) u_on_rx (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sync_on_in),
    .invert(on_inv),
    .enable(on_is_sync && !on_busy),
    .level(on_level),
    .pulse(on_rx_pulse)
  );

  sync_line_rx #(
    .MIN_CYCLES(PULSE_LEN)
  ) u_off_rx (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in(sync_off_in),
    .invert(off_inv),
    .enable(off_is_sync && !off_busy),
    .level(off_level),
    .pulse(off_rx_pulse)
  );

  // ----------------------------------------------------------------
  // pwm waveform
  // ----------------------------------------------------------------
  // pwm source
  wire logic pwm_wrap = (pwm_count >= pwm_period - PWM_W'(1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_count <= '0;
      pwm_bit <= 1'b0;
    end else begin
      pwm_count <= pwm_wrap ? '0 : pwm_count + PWM_W'(1);
      pwm_bit <= (pwm_count < pwm_duty);
    end
  end

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  // output function value
  wire logic on_bit = on_is_out ? out_value(on_val, pwm_bit) : 1'b1;
  wire logic off_bit = off_is_out ? out_value(off_val, pwm_bit) : 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_on_out <= 1'b1;
      sync_on_oe <= 1'b0;
      sync_off_out <= 1'b1;
      sync_off_oe <= 1'b0;
    end else begin
      sync_on_out <= pin_level(on_bit, on_inv);
      sync_off_out <= pin_level(off_bit, off_inv);
      sync_on_oe <= on_is_out || (on_is_sync && on_busy);
      sync_off_oe <= off_is_out || (off_is_sync && off_busy);
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= sync_pulse_pkg::CTRL_RESET;
      pwm_period <= PWM_W'(sync_pulse_pkg::PWM_PERIOD_RESET);
      pwm_duty <= PWM_W'(sync_pulse_pkg::PWM_DUTY_RESET);
    end else begin
      if (wr_ctrl) begin
        ctrl <= pwdata[sync_pulse_pkg::CTRL_WIDTH-1:0];
      end
      if (wr_period) begin
        pwm_period <= pwdata[PWM_W-1:0];
      end
      if (wr_duty) begin
        pwm_duty <= pwdata[PWM_W-1:0];
      end
    end
  end

  // received-pulse flags, set wins over write-one clear
  wire logic clr_on_seen = wr_status && pwdata[sync_pulse_pkg::STAT_ON_SEEN];
  wire logic clr_off_seen = wr_status && pwdata[sync_pulse_pkg::STAT_OFF_SEEN];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      on_seen <= 1'b0;
      off_seen <= 1'b0;
    end else begin
      on_seen <= on_rx_pulse || (on_seen && !clr_on_seen);
      off_seen <= off_rx_pulse || (off_seen && !clr_off_seen);
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [31:0] status_word;
  always_comb begin
    status_word = '0;
    status_word[sync_pulse_pkg::STAT_OUTPUT_ON] = output_on;
    status_word[sync_pulse_pkg::STAT_ON_LEVEL] = on_level;
    status_word[sync_pulse_pkg::STAT_OFF_LEVEL] = off_level;
    status_word[sync_pulse_pkg::STAT_ON_TX] = on_busy;
    status_word[sync_pulse_pkg::STAT_OFF_TX] = off_busy;
    status_word[sync_pulse_pkg::STAT_ON_SEEN] = on_seen;
    status_word[sync_pulse_pkg::STAT_OFF_SEEN] = off_seen;
  end

  wire logic [31:0] rd_mux =
    hit_ctrl ? {{(32 - sync_pulse_pkg::CTRL_WIDTH){1'b0}}, ctrl} :
    hit_status ? status_word :
    hit_period ? {{(32 - PWM_W){1'b0}}, pwm_period} :
    hit_duty ? {{(32 - PWM_W){1'b0}}, pwm_duty} :
    32'h0000_0000;

  // captured in the setup cycle, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase && !pwrite) begin
      prdata <= rd_mux;
    end
  end

endmodule // output_sync_pulse_control

// ---- src/sync_line_rx.sv ----
// Purpose: synchronise one sync line and qualify its active pulses
// Assumes: pin_in is asynchronous to pclk
// Notes: level is the polarity-corrected digital value
`timescale 1ns/100ps
module sync_line_rx #(
  parameter int MIN_CYCLES = sync_pulse_pkg::PULSE_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_in,
  input wire logic invert,
  input wire logic enable,
  output logic level,
  output logic pulse
);

  localparam int CW = sync_pulse_pkg::PULSE_CNT_W;
  localparam logic [CW-1:0] CNT_LAST = CW'(MIN_CYCLES - 1);
  localparam logic [CW-1:0] CNT_DONE = CW'(MIN_CYCLES);

  logic meta;
  logic pin_sync;
  logic [CW-1:0] count;
  wire logic active_bit;
  wire logic counting;

  // ----------------------------------------------------------------
  // two-flop synchroniser
  // ----------------------------------------------------------------
  // sync to clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b1;
      pin_sync <= 1'b1;
    end else begin
      meta <= pin_in;
      pin_sync <= meta;
    end
  end

  assign active_bit = ~pin_sync ^ invert;
  assign counting = enable && active_bit;

  // ----------------------------------------------------------------
  // level and pulse qualifier
  // ----------------------------------------------------------------
  // sample outside level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= 1'b0;
    end else begin
      level <= active_bit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      pulse <= 1'b0;
    end else begin
      pulse <= counting && (count == CNT_LAST);
      if (!counting) begin
        count <= '0;
      end else if (count != CNT_DONE) begin
        count <= count + CW'(1);
      end
    end
  end

endmodule // sync_line_rx
